// ---- tlv_pkg.sv ----
package tlv_pkg;
	// Descriptor area addresses
	localparam logic [15:0] CSUM_LO_ADDR = 16'h1A02;
	localparam logic [15:0] CSUM_HI_ADDR = 16'h1A03;
	localparam logic [15:0] COVER_FIRST_ADDR = 16'h1A04;
	localparam logic [15:0] COVER_LAST_ADDR = 16'h1AFF;
	// CRC engine
	localparam logic [15:0] CRC_SEED = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	// Memory-discovery entry fields
	localparam int TYPE_MSB = 15;
	localparam int TYPE_LSB = 13;
	localparam int SIZE_MSB = 12;
	localparam int SIZE_LSB = 9;
	localparam int MORE_BIT = 8;
	localparam int UNIT_BIT = 7;
	localparam int ADDRV_MSB = 6;
	localparam logic [2:0] TYPE_RAM = 3'h1;
	localparam logic [3:0] SIZE_16KB = 4'h8;
	localparam logic [23:0] UNIT_SMALL = 24'h000200;
	localparam logic [23:0] UNIT_LARGE = 24'h010000;
	// Calibration scaling
	localparam int CAL_SHIFT = 15;
	localparam int TEMP_LOW_C = 30;
	localparam int TEMP_HIGH_C = 85;
	localparam logic signed [31:0] TEMP_SPAN = 32'(TEMP_HIGH_C - TEMP_LOW_C);
	localparam logic signed [31:0] TEMP_BASE = 32'(TEMP_LOW_C);
	localparam logic [5:0] DIV_STEPS = 6'h20;

	typedef enum logic [1:0] {CK_IDLE, CK_REQ, CK_WAIT, CK_END} chk_state_t;
	typedef enum logic [1:0] {CA_IDLE, CA_GAIN, CA_DIV, CA_DONE} cal_state_t;
	typedef enum logic [2:0] {OP_REF, OP_GAIN, OP_OFFSET, OP_GAIN_OFFSET, OP_TEMP} cal_op_t;
endpackage : tlv_pkg

// ---- tlv_divider.sv ----
`timescale 1ns/1ps
// Signed restoring divider, one quotient bit per cycle, truncates toward zero
module tlv_divider (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Request
	input wire logic start,
	input wire logic signed [31:0] dividend,
	input wire logic signed [16:0] divisor,
	// Answer
	output logic busy,
	output logic done,
	output logic signed [31:0] quotient
);
	typedef struct packed {
		logic run;
		logic [5:0] cnt;
		logic [17:0] rem;
		logic [31:0] quo;
		logic [16:0] dmag;
		logic neg;
		logic done;
		logic [31:0] result;
	} div_st_t;

	div_st_t st_q, st_d;

	// One step of long division per cycle
	always_comb begin
		logic [18:0] rem_sh;
		rem_sh = '0;
		st_d = st_q;
		st_d.done = 1'b0;
		if (start && !st_q.run) begin
			st_d.run = 1'b1;
			st_d.cnt = tlv_pkg::DIV_STEPS;
			st_d.rem = '0;
			st_d.quo = dividend[31] ? 32'(-dividend) : dividend;
			st_d.dmag = divisor[16] ? 17'(-divisor) : divisor;
			st_d.neg = dividend[31] ^ divisor[16];
		end else if (st_q.run) begin
			rem_sh = {st_q.rem, st_q.quo[31]};
			if (rem_sh >= {2'h0, st_q.dmag}) begin
				st_d.rem = 18'(rem_sh - {2'h0, st_q.dmag});
				st_d.quo = {st_q.quo[30:0], 1'b1};
			end else begin
				st_d.rem = rem_sh[17:0];
				st_d.quo = {st_q.quo[30:0], 1'b0};
			end
			st_d.cnt = st_q.cnt - 6'h01;
			if (st_q.cnt == 6'h01) begin
				st_d.run = 1'b0;
				st_d.done = 1'b1;
				st_d.result = st_q.neg ? 32'(-st_d.quo) : st_d.quo;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign busy = st_q.run;
	assign done = st_q.done;
	assign quotient = st_q.result;
endmodule : tlv_divider

// ---- descriptor_table_checker.sv ----
`timescale 1ns/1ps
module descriptor_table_checker (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Descriptor memory read port, data one cycle after rd_en
	output logic rd_en,
	output logic [15:0] rd_addr,
	input wire logic [7:0] rd_data,
	// Checksum check control and status
	input wire logic check_start,
	output logic check_busy,
	output logic check_done,
	output logic check_pass,
	output logic check_fail,
	output logic [15:0] crc_seed_and_result,
	// Memory-discovery entry decode
	input wire logic entry_valid,
	input wire logic [15:0] entry_word,
	output logic region_valid,
	output logic [2:0] region_type,
	output logic [3:0] region_size,
	output logic region_is_ram,
	output logic region_is_16kb,
	output logic region_more,
	output logic [23:0] region_start,
	// Interrupt ordering between two descriptor entries
	input wire logic prio_valid_in,
	input wire logic [7:0] prio_a_pid,
	input wire logic [3:0] prio_a_index,
	input wire logic [7:0] prio_b_pid,
	input wire logic [3:0] prio_b_index,
	output logic prio_valid,
	output logic prio_same_group,
	output logic prio_a_higher,
	// Calibration words
	input wire logic [15:0] ref_low_level_factor,
	input wire logic [15:0] ref_mid_level_factor,
	input wire logic [15:0] ref_high_level_factor,
	input wire logic [15:0] gain_factor,
	input wire logic [15:0] offset_word,
	input wire logic [15:0] temp_reading_low_point,
	input wire logic [15:0] temp_reading_high_point,
	// Calibration request and answer
	input wire logic cal_start,
	input wire logic [2:0] cal_op,
	input wire logic [1:0] ref_level,
	input wire logic [15:0] raw_result,
	output logic cal_busy,
	output logic cal_done,
	output logic signed [15:0] cal_result
);
	typedef struct packed {
		tlv_pkg::chk_state_t chk;
		logic [15:0] addr;
		logic [15:0] crc;
		logic [15:0] stored;
		logic chk_done;
		logic chk_pass;
		logic chk_fail;
		logic reg_valid;
		logic [2:0] reg_type;
		logic [3:0] reg_size;
		logic reg_more;
		logic [23:0] reg_start;
		logic prio_valid;
		logic prio_same;
		logic prio_a_hi;
		tlv_pkg::cal_state_t cal;
		logic [2:0] op;
		logic [15:0] gained;
		logic signed [15:0] cal_res;
		logic cal_done;
		logic div_go;
		logic signed [31:0] div_num;
		logic signed [16:0] div_den;
	} st_t;

	st_t st_q, st_d;
	logic div_busy;
	logic div_done;
	logic signed [31:0] div_quot;

	// One byte through the CRC, data bit-reversed so bit 0 enters first
	function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		logic fb;
		c = crc;
		for (int i = 0; i < 8; i++) begin
			fb = c[15] ^ data[i];
			c = {c[14:0], 1'b0} ^ (fb ? tlv_pkg::CRC_POLY : 16'h0000);
		end
		return c;
	endfunction : crc_byte

	// Multiply by a 2^15-scaled factor; keeps the low 16 bits of the quotient
	function automatic logic [15:0] scale15(input logic [15:0] value, input logic [15:0] factor);
		logic [31:0] prod;
		prod = {16'h0000, value} * {16'h0000, factor};
		return 16'(prod >> tlv_pkg::CAL_SHIFT);
	endfunction : scale15

	// Within one group the lower sub-index ranks higher
	function automatic logic ranks_above(input logic [3:0] a_idx, input logic [3:0] b_idx);
		return a_idx < b_idx;
	endfunction : ranks_above

	// Next state for every part; outputs below only read registers
	always_comb begin
		logic [15:0] ref_factor;
		logic signed [16:0] diff;
		logic signed [31:0] diff_wide;
		ref_factor = ref_low_level_factor;
		diff = '0;
		diff_wide = '0;
		st_d = st_q;
		st_d.chk_done = 1'b0;
		st_d.cal_done = 1'b0;
		st_d.div_go = 1'b0;
		st_d.reg_valid = 1'b0;
		st_d.prio_valid = 1'b0;

		// Checksum walk: read each byte, absorb, compare at the end
		unique case (st_q.chk)
			tlv_pkg::CK_IDLE: begin
				// A start while busy never reaches this branch
				if (check_start) begin
					st_d.chk = tlv_pkg::CK_REQ;
					st_d.addr = tlv_pkg::CSUM_LO_ADDR;
					st_d.crc = tlv_pkg::CRC_SEED;
					st_d.chk_pass = 1'b0;
					st_d.chk_fail = 1'b0;
				end
			end
			tlv_pkg::CK_REQ: begin
				// Read strobe high for exactly this cycle
				st_d.chk = tlv_pkg::CK_WAIT;
			end
			tlv_pkg::CK_WAIT: begin
				// Stored checksum bytes stay out of the CRC stream
				if (st_q.addr == tlv_pkg::CSUM_LO_ADDR) begin
					st_d.stored[7:0] = rd_data;
				end else if (st_q.addr == tlv_pkg::CSUM_HI_ADDR) begin
					st_d.stored[15:8] = rd_data;
				end else begin
					st_d.crc = crc_byte(st_q.crc, rd_data);
				end
				// Fixed one-cycle read latency; a slower memory would need a wait
				if (st_q.addr == tlv_pkg::COVER_LAST_ADDR) begin
					st_d.chk = tlv_pkg::CK_END;
				end else begin
					st_d.addr = st_q.addr + 16'h0001;
					st_d.chk = tlv_pkg::CK_REQ;
				end
			end
			tlv_pkg::CK_END: begin
				// Compare only once the last covered byte is in
				st_d.chk_done = 1'b1;
				st_d.chk_pass = (st_q.crc == st_q.stored);
				st_d.chk_fail = (st_q.crc != st_q.stored);
				st_d.chk = tlv_pkg::CK_IDLE;
			end
		endcase

		// Memory-discovery entry fields
		// Fields hold until the next entry; only the valid bit pulses
		if (entry_valid) begin
			st_d.reg_valid = 1'b1;
			st_d.reg_type = entry_word[tlv_pkg::TYPE_MSB:tlv_pkg::TYPE_LSB];
			st_d.reg_size = entry_word[tlv_pkg::SIZE_MSB:tlv_pkg::SIZE_LSB];
			st_d.reg_more = entry_word[tlv_pkg::MORE_BIT];
			st_d.reg_start = (entry_word[tlv_pkg::UNIT_BIT] ? tlv_pkg::UNIT_LARGE :
				tlv_pkg::UNIT_SMALL) * {17'h00000, entry_word[tlv_pkg::ADDRV_MSB:0]};
		end

		// Implied ordering: channel 0 before others, RX before TX, lower port first
		// Different groups never rank against each other
		if (prio_valid_in) begin
			st_d.prio_valid = 1'b1;
			st_d.prio_same = (prio_a_pid == prio_b_pid);
			st_d.prio_a_hi = (prio_a_pid == prio_b_pid) &&
				ranks_above(prio_a_index, prio_b_index);
		end

		// Calibration datapath; temperature needs the serial divider
		// Unused level code falls back to the low factor
		unique case (ref_level)
			2'h1: ref_factor = ref_mid_level_factor;
			2'h2: ref_factor = ref_high_level_factor;
			default: ref_factor = ref_low_level_factor;
		endcase
		unique case (st_q.cal)
			tlv_pkg::CA_IDLE: begin
				if (cal_start) begin
					st_d.op = cal_op;
					st_d.cal = tlv_pkg::CA_DONE;
					// Single-step operations answer two cycles after the take
					unique case (cal_op)
						tlv_pkg::OP_REF: st_d.cal_res = scale15(raw_result, ref_factor);
						tlv_pkg::OP_GAIN: st_d.cal_res = scale15(raw_result, gain_factor);
						tlv_pkg::OP_OFFSET: st_d.cal_res = 16'(raw_result + offset_word);
						tlv_pkg::OP_GAIN_OFFSET: begin
							st_d.gained = scale15(raw_result, gain_factor);
							st_d.cal = tlv_pkg::CA_GAIN;
						end
						tlv_pkg::OP_TEMP: begin
							// 17-bit difference keeps a reading below the low point negative
							diff = $signed({1'b0, raw_result}) -
								$signed({1'b0, temp_reading_low_point});
							diff_wide = 32'(diff);
							st_d.div_num = 32'(diff_wide * tlv_pkg::TEMP_SPAN);
							st_d.div_den = $signed({1'b0, temp_reading_high_point}) -
								$signed({1'b0, temp_reading_low_point});
							st_d.div_go = 1'b1;
							st_d.cal = tlv_pkg::CA_DIV;
						end
						default: st_d.cal_res = $signed(raw_result);
					endcase
				end
			end
			tlv_pkg::CA_GAIN: begin
				// Signed offset added only after the gain step
				st_d.cal_res = $signed(16'(st_q.gained + offset_word));
				st_d.cal = tlv_pkg::CA_DONE;
			end
			tlv_pkg::CA_DIV: begin
				// No limit needed; the divider always ends after its fixed steps
				if (div_done) begin
					st_d.cal_res = 16'(div_quot + tlv_pkg::TEMP_BASE);
					st_d.cal = tlv_pkg::CA_DONE;
				end
			end
			tlv_pkg::CA_DONE: begin
				// One-cycle answer pulse; result stays until the next operation
				st_d.cal_done = 1'b1;
				st_d.cal = tlv_pkg::CA_IDLE;
			end
		endcase
	end

	// One register for all state; clearing it zeroes every output
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Division by zero (equal readings) gives a meaningless temperature
	// Used by the temperature operation only; idle otherwise
	tlv_divider u_div (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.start(st_q.div_go),
		.dividend(st_q.div_num),
		.divisor(st_q.div_den),
		.busy(div_busy),
		.done(div_done),
		.quotient(div_quot)
	);

	// Read port and checksum status
	assign rd_en = (st_q.chk == tlv_pkg::CK_REQ);
	assign rd_addr = st_q.addr;
	assign check_busy = (st_q.chk != tlv_pkg::CK_IDLE);
	assign check_done = st_q.chk_done;
	assign check_pass = st_q.chk_pass;
	assign check_fail = st_q.chk_fail;
	assign crc_seed_and_result = st_q.crc;

	// Region fields, held until the next entry
	assign region_valid = st_q.reg_valid;
	assign region_type = st_q.reg_type;
	assign region_size = st_q.reg_size;
	assign region_is_ram = (st_q.reg_type == tlv_pkg::TYPE_RAM);
	assign region_is_16kb = (st_q.reg_size == tlv_pkg::SIZE_16KB);
	assign region_more = st_q.reg_more;
	assign region_start = st_q.reg_start;

	// Ordering result
	assign prio_valid = st_q.prio_valid;
	assign prio_same_group = st_q.prio_same;
	assign prio_a_higher = st_q.prio_a_hi;

	// Calibration answer; busy covers the divider as well
	assign cal_busy = (st_q.cal != tlv_pkg::CA_IDLE) || div_busy;
	assign cal_done = st_q.cal_done;
	assign cal_result = st_q.cal_res;
endmodule : descriptor_table_checker

// ---- descriptor_table_checker_asserts.sv ----
`timescale 1ns/1ps
module descriptor_table_checker_asserts (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Descriptor read port and checksum status
	input wire logic rd_en,
	input wire logic [15:0] rd_addr,
	input wire logic check_start,
	input wire logic check_busy,
	input wire logic check_done,
	input wire logic check_pass,
	input wire logic check_fail,
	// Entry decode and ordering
	input wire logic entry_valid,
	input wire logic [15:0] entry_word,
	input wire logic region_valid,
	input wire logic [2:0] region_type,
	input wire logic [3:0] region_size,
	input wire logic [23:0] region_start,
	input wire logic prio_valid_in,
	input wire logic [7:0] prio_a_pid,
	input wire logic [3:0] prio_a_index,
	input wire logic [7:0] prio_b_pid,
	input wire logic [3:0] prio_b_index,
	input wire logic prio_valid,
	input wire logic prio_a_higher,
	// Calibration handshake
	input wire logic cal_start,
	input wire logic cal_busy,
	input wire logic [2:0] cal_op,
	input wire logic cal_done
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Reads since the last accepted start; a counter keeps the long count cheap
	logic [8:0] n_rd_q;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			n_rd_q <= 9'h000;
		else if (check_start && !check_busy)
			n_rd_q <= 9'h000;
		else if (rd_en)
			n_rd_q <= n_rd_q + 9'h001;
	end
	sequence s_take;
		check_start && !check_busy;
	endsequence
	sequence s_head;
		rd_en && rd_addr == 16'h1A02 ##2 rd_en && rd_addr == 16'h1A03;
	endsequence
	property p_head;
		s_take |=> s_head;
	endproperty
	property p_range;
		rd_en |-> rd_addr >= 16'h1A02 && rd_addr <= 16'h1AFF;
	endproperty
	property p_step;
		rd_en ##2 rd_en |-> rd_addr == $past(rd_addr, 2) + 16'h0001;
	endproperty
	property p_len;
		check_done |-> n_rd_q == 9'h0FE;
	endproperty
	property p_verdict;
		check_done |-> check_pass != check_fail ##1 !check_done;
	endproperty
	property p_region;
		entry_valid |=> region_valid && {region_type, region_size} == ($past(entry_word) >> 9);
	endproperty
	property p_start;
		entry_valid && !entry_word[7] |=>
			region_start == 24'h000200 * ($past(entry_word) & 16'h007F);
	endproperty
	property p_prio;
		prio_valid_in |=> prio_valid && prio_a_higher == ($past(prio_a_pid) == $past(prio_b_pid)
			&& $past(prio_a_index) < $past(prio_b_index));
	endproperty
	property p_gain;
		cal_start && !cal_busy && cal_op == 3'h1 |-> ##2 cal_done;
	endproperty
	a_head: assert property (p_head) else $error("bad first reads");
	a_range: assert property (p_range) else $error("read outside area");
	a_step: assert property (p_step) else $error("reads not ascending");
	a_len: assert property (p_len) else $error("wrong read count");
	a_verdict: assert property (p_verdict) else $error("bad verdict");
	a_region: assert property (p_region) else $error("bad type or size");
	a_start: assert property (p_start) else $error("bad start address");
	a_prio: assert property (p_prio) else $error("bad ordering");
	a_gain: assert property (p_gain) else $error("gain answer late");
endmodule : descriptor_table_checker_asserts

bind descriptor_table_checker descriptor_table_checker_asserts u_asserts (.*);

// ---- tlv_mem_model.sv ----
`timescale 1ns/1ps
module tlv_mem_model (
	// Clock
	input wire logic clk_sys,
	// Read port
	input wire logic rd_en,
	input wire logic [15:0] rd_addr,
	output logic [7:0] rd_data
);
	logic [7:0] mem [0:255];
	initial rd_data = 8'hA5;
	// Idle or foreign reads show the inverse, so a late sample cannot pass
	always @(posedge clk_sys) begin
		if (rd_en && rd_addr[15:8] == 8'h1A)
			rd_data <= mem[rd_addr[7:0]];
		else
			rd_data <= ~rd_data;
	end
endmodule : tlv_mem_model

// ---- descriptor_table_checker_tb_top.sv ----
`timescale 1ns/1ps
module descriptor_table_checker_tb_top;
	logic clk_sys, resetn, check_start, entry_valid, prio_valid_in, cal_start, rd_en, check_busy;
	logic check_done, check_pass, check_fail, region_valid, region_is_ram, region_is_16kb;
	logic region_more, prio_valid, prio_same_group, prio_a_higher, cal_busy, cal_done;
	logic [7:0] rd_data, prio_a_pid, prio_b_pid;
	logic [15:0] rd_addr, crc_seed_and_result, entry_word, raw_result, crc, offset_word;
	logic [15:0] ref_low_level_factor, ref_mid_level_factor, ref_high_level_factor, gain_factor;
	logic [15:0] temp_reading_low_point, temp_reading_high_point;
	logic [3:0] prio_a_index, prio_b_index, region_size;
	logic [2:0] cal_op, region_type;
	logic [1:0] ref_level;
	logic [23:0] region_start;
	logic signed [15:0] cal_result;
	int miscompares, n_compared;
	descriptor_table_checker DUT (.*);
	tlv_mem_model u_mem (.clk_sys(clk_sys), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data));
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic test_done();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done
	// Bounded wait for a pulse, sampled mid-cycle
	task automatic wait_for(input bit on_cal, input int lim);
		int n;
		n = 0;
		while ((on_cal ? cal_done : check_done) !== 1'b1 && n < lim) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= lim) begin
			miscompares++;
			$display("mismatch wait expected 1 seen 0");
			test_done();
		end
	endtask : wait_for
	// Flip selects which stored byte is spoiled; zero keeps the checksum good
	task automatic t_check(input logic [15:0] flip);
		crc = tlv_pkg::CRC_SEED;
		for (int a = 4; a < 256; a++) begin
			for (int b = 0; b < 8; b++)
				crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ u_mem.mem[a][b]) ? tlv_pkg::CRC_POLY : 16'h0000);
		end
		u_mem.mem[2] = crc[7:0] ^ flip[7:0];
		u_mem.mem[3] = crc[15:8] ^ flip[15:8];
		check_start = 1'b1;
		@(negedge clk_sys);
		check_start = 1'b0;
		chk("cbusy", 1'b1, check_busy);
		wait_for(1'b0, 600);
		chk("cidle", 1'b0, check_busy);
		chk("crc", crc, crc_seed_and_result);
		chk("pass", flip == 16'h0000, check_pass);
		chk("fail", flip != 16'h0000, check_fail);
		$display("test checksum done");
	endtask : t_check
	task automatic t_entry();
		logic [15:0] w [3] = '{16'h300E, 16'h962E, 16'h2385};
		foreach (w[i]) begin
			entry_valid = 1'b1;
			entry_word = w[i];
			@(negedge clk_sys);
			chk("rvalid", 1'b1, region_valid);
			chk("rtype", w[i][15:13], region_type);
			chk("rsize", w[i][12:9], region_size);
			chk("ram", w[i][15:13] == 3'h1, region_is_ram);
			chk("16kb", w[i][12:9] == 4'h8, region_is_16kb);
			chk("more", w[i][8], region_more);
			chk("start", (w[i][7] ? 24'h010000 : 24'h000200) * w[i][6:0], region_start);
		end
		entry_valid = 1'b0;
		$display("test entry done");
	endtask : t_entry
	task automatic t_prio();
		logic [23:0] p [5] = '{24'h810812, 24'h813810, 24'h300301, 24'h512511, 24'h523534};
		foreach (p[i]) begin
			prio_valid_in = 1'b1;
			{prio_a_pid, prio_a_index, prio_b_pid, prio_b_index} = p[i];
			@(negedge clk_sys);
			chk("pvalid", 1'b1, prio_valid);
			chk("same", p[i][23:16] == p[i][11:4], prio_same_group);
			chk("higher", p[i][23:16] == p[i][11:4] && p[i][15:12] < p[i][3:0], prio_a_higher);
		end
		prio_valid_in = 1'b0;
		$display("test ordering done");
	endtask : t_prio
	task automatic t_cal(input logic [2:0] op, input logic [1:0] lvl, input logic [15:0] raw,
		input logic [15:0] exp);
		cal_op = op;
		ref_level = lvl;
		raw_result = raw;
		cal_start = 1'b1;
		@(negedge clk_sys);
		cal_start = 1'b0;
		chk("calbusy", 1'b1, cal_busy);
		wait_for(1'b1, 60);
		chk("cal", exp, $unsigned(cal_result));
		chk("calidle", 1'b0, cal_busy);
	endtask : t_cal
	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// Main sequence
	initial begin
		resetn = 1'b0;
		{check_start, entry_valid, prio_valid_in, cal_start} = 4'h0;
		{entry_word, prio_a_pid, prio_b_pid, prio_a_index, prio_b_index} = 40'h0;
		{cal_op, ref_level, raw_result} = 21'h0;
		{ref_low_level_factor, ref_mid_level_factor, ref_high_level_factor} = 48'h7BBB_8123_7F00;
		{gain_factor, offset_word} = 32'h4000_FFF0;
		{temp_reading_low_point, temp_reading_high_point} = 32'h0100_0164;
		for (int a = 0; a < 256; a++)
			u_mem.mem[a] = 8'(a * 37 + 5);
		repeat (6) @(negedge clk_sys);
		resetn = 1'b1;
		t_check(16'h0000);
		t_check(16'h0001);
		t_check(16'h0100);
		t_entry();
		t_prio();
		t_cal(3'h0, 2'h0, 16'h0100, 16'((32'h0100 * ref_low_level_factor) >> 15));
		t_cal(3'h0, 2'h1, 16'h0100, 16'((32'h0100 * ref_mid_level_factor) >> 15));
		t_cal(3'h0, 2'h2, 16'h0100, 16'((32'h0100 * ref_high_level_factor) >> 15));
		t_cal(3'h0, 2'h3, 16'h0100, 16'((32'h0100 * ref_low_level_factor) >> 15));
		t_cal(3'h1, 2'h0, 16'h0800, 16'((32'h0800 * gain_factor) >> 15));
		t_cal(3'h2, 2'h0, 16'h0100, 16'h0100 + offset_word);
		t_cal(3'h3, 2'h0, 16'h0800, 16'((32'h0800 * gain_factor) >> 15) + offset_word);
		t_cal(3'h4, 2'h0, 16'h0107, 16'h0021);
		t_cal(3'h4, 2'h0, 16'h00F9, 16'h001B);
		$display("test calibration done");
		test_done();
	end
endmodule : descriptor_table_checker_tb_top
